// ### uhfc_pkg.sv
/*
  Constants shared by the flow-controlled serial port: timing,
  frame layout, reset levels and the status word layout.
  Assumes a 50 MHz system clock and a single reset domain.
*/
`default_nettype none
package uhfc_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          MAX_BAUD      = 1_000_000;
  // fastest bit period in clocks, rounded down to a whole clock count
  localparam int          MIN_DIV       = CLK_HZ / MAX_BAUD;
  localparam int          DIV_W         = 16;
  localparam logic [15:0] DIV_RESET     = 16'h01B2; // 115200 baud
  localparam int          DATA_BITS     = 8;
  localparam logic        LINE_IDLE     = 1'b1;
  localparam logic        START_LEVEL   = 1'b0;
  localparam logic        STOP_LEVEL    = 1'b1;
  localparam logic        HS_ASSERTED   = 1'b0;
  localparam logic        HS_DEASSERTED = 1'b1;
  localparam logic        PULL_UP_ON    = 1'b1;
  localparam logic        PULL_DOWN_ON  = 1'b1;
  localparam int          ST_OVERRUN    = 0;
  localparam int          ST_FRAMING    = 1;
  localparam int          ST_PARITY     = 2;
  localparam int          ST_W          = 3;

  typedef enum logic [4:0] {
    UHFC_IDLE   = 5'h01,
    UHFC_START  = 5'h02,
    UHFC_DATA   = 5'h04,
    UHFC_PARITY = 5'h08,
    UHFC_STOP   = 5'h10
  } uhfc_state_t;
endpackage
`default_nettype wire

// ### uhfc_uart.sv
/*
  Full-duplex asynchronous serial port with active-low hardware
  handshaking and optional ninth-bit parity.
  Assumes serial pins arrive asynchronously and are synchronised here;
  user-side strobes come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module uhfc_uart
  import uhfc_pkg::*;
#(
  parameter logic [DIV_W-1:0] DIV_INIT = DIV_RESET
)(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [DIV_W-1:0] baud_div,
  input  wire logic             parity_en,
  input  wire logic             parity_odd,
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output logic [7:0]            rx_data,
  output logic                  rx_valid,
  input  wire logic             rx_take,
  output logic [ST_W-1:0]       status,
  input  wire logic [ST_W-1:0]  status_clear,
  output logic                  gp_pin_serial_out,
  output logic                  gp_pin_serial_out_oe,
  input  wire logic             gp_pin_serial_in,
  output logic                  gp_pin_serial_in_pu,
  output logic                  gp_pin_permit_out,
  output logic                  gp_pin_permit_out_oe,
  input  wire logic             gp_pin_permit_in,
  output logic                  gp_pin_permit_in_pd
);
  // divider below the 1 Mbps limit is clamped so the rate never exceeds it
  logic [DIV_W-1:0] div_eff;
  always_comb
  begin
    div_eff = (baud_div < DIV_W'(MIN_DIV)) ? DIV_W'(MIN_DIV)
                                           : baud_div;
  end

  // two-stage synchronisers for the receive and clear-to-send pins
  logic rx_s1, rx_s2, cts_s1, cts_s2;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_s1  <= LINE_IDLE;
      rx_s2  <= LINE_IDLE;
      cts_s1 <= HS_ASSERTED;
      cts_s2 <= HS_ASSERTED;
    end
    else
    begin
      rx_s1  <= gp_pin_serial_in;
      rx_s2  <= rx_s1;
      cts_s1 <= gp_pin_permit_in;
      cts_s2 <= cts_s1;
    end
  end

  // ---------------- transmitter ----------------
  uhfc_state_t      tx_st, next_tx_st;
  logic [DIV_W-1:0] tx_cnt, next_tx_cnt;
  logic [2:0]       tx_bit, next_tx_bit;
  logic [7:0]       tx_sh, next_tx_sh;
  logic             tx_par, next_tx_par;
  logic             tx_line, next_tx_line;
  logic             tx_rdy, next_tx_rdy;
  logic             tx_tick;

  // a new character starts only while the host asserts clear-to-send
  always_comb
  begin
    next_tx_st   = tx_st;
    next_tx_cnt  = tx_cnt;
    next_tx_bit  = tx_bit;
    next_tx_sh   = tx_sh;
    next_tx_par  = tx_par;
    next_tx_line = tx_line;
    next_tx_rdy  = tx_rdy;
    tx_tick      = (tx_cnt == DIV_W'(1));
    if (tx_st != UHFC_IDLE)
      next_tx_cnt = tx_tick ? div_eff : tx_cnt - DIV_W'(1);
    case (tx_st)
      UHFC_IDLE:
      begin
        next_tx_line = LINE_IDLE;
        if (tx_valid && tx_rdy && cts_s2 == HS_ASSERTED)
        begin
          next_tx_st   = UHFC_START;
          next_tx_sh   = tx_data;
          next_tx_par  = (^tx_data) ^ parity_odd;
          next_tx_line = START_LEVEL;
          next_tx_cnt  = div_eff;
          next_tx_rdy  = 1'b0;
        end
      end
      UHFC_START:
        if (tx_tick)
        begin
          next_tx_st   = UHFC_DATA;
          next_tx_bit  = 3'h0;
          next_tx_line = tx_sh[0];
        end
      UHFC_DATA:
        if (tx_tick)
        begin
          next_tx_sh  = {1'b0, tx_sh[7:1]};
          next_tx_bit = tx_bit + 3'h1;
          if (tx_bit == 3'(DATA_BITS - 1))
          begin
            next_tx_st   = parity_en ? UHFC_PARITY : UHFC_STOP;
            next_tx_line = parity_en ? tx_par : STOP_LEVEL;
          end
          else
            next_tx_line = tx_sh[1];
        end
      UHFC_PARITY:
        if (tx_tick)
        begin
          next_tx_st   = UHFC_STOP;
          next_tx_line = STOP_LEVEL;
        end
      UHFC_STOP:
        if (tx_tick)
        begin
          next_tx_st  = UHFC_IDLE;
          next_tx_rdy = 1'b1;
        end
      default:
        next_tx_st = UHFC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_st   <= UHFC_IDLE;
      tx_cnt  <= DIV_INIT;
      tx_bit  <= 3'h0;
      tx_sh   <= 8'h00;
      tx_par  <= 1'b0;
      tx_line <= LINE_IDLE;
      tx_rdy  <= 1'b1;
    end
    else
    begin
      tx_st   <= next_tx_st;
      tx_cnt  <= next_tx_cnt;
      tx_bit  <= next_tx_bit;
      tx_sh   <= next_tx_sh;
      tx_par  <= next_tx_par;
      tx_line <= next_tx_line;
      tx_rdy  <= next_tx_rdy;
    end
  end

  // ---------------- receiver ----------------
  uhfc_state_t      rx_st, next_rx_st;
  logic [DIV_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0]       rx_bit, next_rx_bit;
  logic [7:0]       rx_sh, next_rx_sh;
  logic [7:0]       rx_hold, next_rx_hold;
  logic             rx_full, next_rx_full;
  logic             rx_perr, next_rx_perr;
  logic [ST_W-1:0]  st, next_st;
  logic             rts, next_rts;
  logic             rx_tick;

  // sampling at mid-bit; the start bit is rechecked to reject glitches
  always_comb
  begin
    next_rx_st   = rx_st;
    next_rx_cnt  = rx_cnt;
    next_rx_bit  = rx_bit;
    next_rx_sh   = rx_sh;
    next_rx_hold = rx_hold;
    next_rx_perr = rx_perr;
    next_rx_full = rx_full && !rx_take;
    next_st      = st & ~status_clear; // set below wins over clear
    rx_tick      = (rx_cnt == DIV_W'(1));
    if (rx_st != UHFC_IDLE)
      next_rx_cnt = rx_tick ? div_eff : rx_cnt - DIV_W'(1);
    case (rx_st)
      UHFC_IDLE:
        if (rx_s2 == START_LEVEL) // steady high is no activity
        begin
          next_rx_st  = UHFC_START;
          next_rx_cnt = {1'b0, div_eff[DIV_W-1:1]};
        end
      UHFC_START:
        if (rx_tick)
        begin
          next_rx_st  = (rx_s2 == START_LEVEL) ? UHFC_DATA : UHFC_IDLE;
          next_rx_bit = 3'h0;
          next_rx_perr = parity_odd;
        end
      UHFC_DATA:
        if (rx_tick)
        begin
          next_rx_sh   = {rx_s2, rx_sh[7:1]}; // lsb first
          next_rx_perr = rx_perr ^ rx_s2;
          next_rx_bit  = rx_bit + 3'h1;
          if (rx_bit == 3'(DATA_BITS - 1))
            next_rx_st = parity_en ? UHFC_PARITY : UHFC_STOP;
        end
      UHFC_PARITY:
        if (rx_tick)
        begin
          next_rx_perr = rx_perr ^ rx_s2;
          next_rx_st   = UHFC_STOP;
        end
      UHFC_STOP:
        if (rx_tick)
        begin
          next_rx_st = UHFC_IDLE;
          if (rx_s2 != STOP_LEVEL)
            next_st[ST_FRAMING] = 1'b1;
          if (parity_en && rx_perr)
            next_st[ST_PARITY] = 1'b1;
          if (rx_full && !rx_take)
            next_st[ST_OVERRUN] = 1'b1; // old character kept
          else
          begin
            next_rx_hold = rx_sh;
            next_rx_full = 1'b1;
          end
        end
      default:
        next_rx_st = UHFC_IDLE;
    endcase
    // deassert request-to-send while the holding word is occupied
    next_rts = next_rx_full ? HS_DEASSERTED : HS_ASSERTED;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_st   <= UHFC_IDLE;
      rx_cnt  <= DIV_INIT;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
      rx_perr <= 1'b0;
      st      <= '0;
      rts     <= HS_ASSERTED;
    end
    else
    begin
      rx_st   <= next_rx_st;
      rx_cnt  <= next_rx_cnt;
      rx_bit  <= next_rx_bit;
      rx_sh   <= next_rx_sh;
      rx_hold <= next_rx_hold;
      rx_full <= next_rx_full;
      rx_perr <= next_rx_perr;
      st      <= next_st;
      rts     <= next_rts;
    end
  end

  // pin direction and pull controls are constant flip-flops from reset
  logic pins_cfg;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pins_cfg <= 1'b1;
    else
      pins_cfg <= 1'b1;
  end

  assign tx_ready             = tx_rdy;
  assign rx_data              = rx_hold;
  assign rx_valid             = rx_full;
  assign status               = st;
  assign gp_pin_serial_out    = tx_line;
  assign gp_pin_serial_out_oe = pins_cfg;
  assign gp_pin_serial_in_pu  = pins_cfg & PULL_UP_ON;
  assign gp_pin_permit_out    = rts;
  assign gp_pin_permit_out_oe = pins_cfg;
  assign gp_pin_permit_in_pd  = pins_cfg & PULL_DOWN_ON;

  // ---------------- assertions ----------------
  property p_tx_idle_high;
    @(posedge ref_clk) disable iff (reset)
      (tx_st == UHFC_IDLE) |-> gp_pin_serial_out;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high)
    else $error("transmit line low while idle");

  property p_start_needs_cts;
    @(posedge ref_clk) disable iff (reset)
      (tx_st == UHFC_IDLE) ##1 (tx_st == UHFC_START) |->
        $past(cts_s2) == HS_ASSERTED;
  endproperty
  a_start_needs_cts: assert property (p_start_needs_cts)
    else $error("character started without clear-to-send");

  property p_start_low;
    @(posedge ref_clk) disable iff (reset)
      (tx_st == UHFC_START) |-> !gp_pin_serial_out;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_stop_high;
    @(posedge ref_clk) disable iff (reset)
      (tx_st == UHFC_STOP) |-> gp_pin_serial_out;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("stop bit not high");

  property p_parity_bit;
    @(posedge ref_clk) disable iff (reset)
      (tx_st == UHFC_PARITY) |->
        gp_pin_serial_out == tx_par;
  endproperty
  a_parity_bit: assert property (p_parity_bit)
    else $error("parity bit wrong");

  property p_rts_follows_full;
    @(posedge ref_clk) disable iff (reset)
      rx_full |-> gp_pin_permit_out == HS_DEASSERTED;
  endproperty
  a_rts_follows_full: assert property (p_rts_follows_full)
    else $error("request-to-send asserted while holding full");

  property p_status_sticky;
    @(posedge ref_clk) disable iff (reset)
      (st[ST_FRAMING] && !status_clear[ST_FRAMING]) |=> st[ST_FRAMING];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("framing flag lost without clear");

  property p_pins_cfg;
    @(posedge ref_clk) disable iff (reset)
      gp_pin_serial_out_oe && gp_pin_permit_out_oe &&
      gp_pin_serial_in_pu && gp_pin_permit_in_pd;
  endproperty
  a_pins_cfg: assert property (p_pins_cfg)
    else $error("pin configuration lost");

  property p_bit_rate;
    @(posedge ref_clk) disable iff (reset)
      (tx_st != UHFC_IDLE) |-> tx_cnt <= div_eff;
  endproperty
  a_bit_rate: assert property (p_bit_rate)
    else $error("bit counter above divider");

  c_tx_frame: cover property (@(posedge ref_clk)
    tx_st == UHFC_STOP ##1 tx_st == UHFC_IDLE);
  c_rx_char: cover property (@(posedge ref_clk) $rose(rx_full));
  c_overrun: cover property (@(posedge ref_clk) $rose(st[ST_OVERRUN]));
  c_parity: cover property (@(posedge ref_clk) $rose(st[ST_PARITY]));
endmodule
`default_nettype wire

// ### uhfc_host.sv
/*
  Behavioural far-side serial peer: sends framed characters into the
  port and decodes what the port sends. Assumes the same ref_clk and
  a bit time of DIV clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module uhfc_host
  import uhfc_pkg::*;
#(
  parameter int DIV = 50
)(
  input  wire logic ref_clk,
  input  wire logic line_in,
  input  wire logic rts_n,
  input  wire logic par_en,
  input  wire logic par_odd,
  output logic      line_out
);
  logic [9:0] got_q[$];
  logic       bad_par = 1'b0;
  logic       bad_stop = 1'b0;
  logic       ignore_rts = 1'b0;

  initial line_out = LINE_IDLE;

  // host transmit feeds the port's receive pin
  task automatic send(input logic [7:0] b);
    logic [10:0] fr;
    int          n;
    fr = par_en ? {STOP_LEVEL ^ bad_stop, ^b ^ par_odd ^ bad_par, b,
                   START_LEVEL}
                : {LINE_IDLE, STOP_LEVEL ^ bad_stop, b, START_LEVEL};
    n = par_en ? 11 : 10;
    // a flow-controlled host waits while the port holds off
    while (rts_n !== HS_ASSERTED && !ignore_rts)
      @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      line_out <= fr[i];
      repeat (DIV - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    line_out <= LINE_IDLE;
    repeat (DIV) @(posedge ref_clk);
  endtask

  // mid-bit sampling receiver, stores {stop, parity, data}
  always
  begin : rx
    logic [7:0] d;
    logic       p;
    @(negedge line_in);
    p = 1'b0;
    repeat (DIV / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge ref_clk);
      d[i] = line_in; // lsb first
    end
    if (par_en)
    begin
      repeat (DIV) @(posedge ref_clk);
      p = line_in;
    end
    repeat (DIV) @(posedge ref_clk);
    got_q.push_back({line_in, p, d});
  end
endmodule
`default_nettype wire

// ### uhfc_uart_tb_top.sv
/*
  Self-checking bench for the flow-controlled serial port.
  Assumes the host peer model and a baud divider of 50 (1 Mbps).
*/
`timescale 1ns/1ps
`default_nettype none
module uhfc_uart_tb_top;
  import uhfc_pkg::*;
  localparam int DIV   = 50;
  localparam int LIMIT = 40000;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] baud_div = 16'h0032;
  logic        parity_en = 1'b0;
  logic        parity_odd = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_valid = 1'b0;
  logic        rx_take = 1'b0;
  logic [2:0]  status_clear = 3'h0;
  logic        cts_n = HS_ASSERTED;
  logic        tx_ready, rx_valid, ser_out, out_oe, ser_in, in_pu;
  logic        rts_n, rts_oe, cts_pd;
  logic [7:0]  rx_data;
  logic [2:0]  status;
  logic [15:0] seed = 16'h2681;
  logic [1:0]  modes[3] = '{2'b00, 2'b10, 2'b11};
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  a, c;

  always #10 ref_clk = ~ref_clk;

  uhfc_uart i_dut (
    .ref_clk(ref_clk), .reset(reset), .baud_div(baud_div),
    .parity_en(parity_en), .parity_odd(parity_odd), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_take(rx_take), .status(status),
    .status_clear(status_clear), .gp_pin_serial_out(ser_out),
    .gp_pin_serial_out_oe(out_oe), .gp_pin_serial_in(ser_in),
    .gp_pin_serial_in_pu(in_pu), .gp_pin_permit_out(rts_n),
    .gp_pin_permit_out_oe(rts_oe), .gp_pin_permit_in(cts_n),
    .gp_pin_permit_in_pd(cts_pd));

  uhfc_host #(.DIV(DIV)) i_host (
    .ref_clk(ref_clk), .line_in(ser_out), .rts_n(rts_n),
    .par_en(parity_en), .par_odd(parity_odd), .line_out(ser_in));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hold the request until the transmitter shows it was taken
  task automatic send_tx(input logic [7:0] b);
    @(posedge ref_clk);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge ref_clk); while (tx_ready !== 1'b0);
    tx_valid <= 1'b0;
  endtask

  task automatic tx_chk(input logic [7:0] b);
    logic [9:0] e;
    while (i_host.got_q.size() == 0)
      @(posedge ref_clk);
    e = i_host.got_q.pop_front();
    chk_val(e[7:0], b);
    if (parity_en)
      chk_bit(e[8], ^b ^ parity_odd);
    chk_bit(e[9], STOP_LEVEL);
    chk_bit(ser_out, LINE_IDLE);
  endtask

  task automatic rx_get(input logic [7:0] b, input logic [2:0] st);
    while (rx_valid !== 1'b1)
      @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    chk_val(rx_data, b);
    chk_val({5'h00, status}, {5'h00, st});
    chk_bit(rts_n, HS_DEASSERTED);
    rx_take <= 1'b1;
    @(posedge ref_clk);
    rx_take <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(rx_valid, 1'b0);
    chk_bit(rts_n, HS_ASSERTED);
  endtask

  task automatic clr();
    status_clear <= 3'h7;
    @(posedge ref_clk);
    status_clear <= 3'h0;
    repeat (2) @(posedge ref_clk);
    chk_val({5'h00, status}, 8'h00);
  endtask

  // hang guard: a run past the ceiling is a failure
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_bit(ser_out, LINE_IDLE);
    chk_bit(out_oe, 1'b1);
    chk_bit(rts_n, HS_ASSERTED);
    chk_bit(rts_oe, 1'b1);
    chk_bit(in_pu, PULL_UP_ON);
    chk_bit(cts_pd, PULL_DOWN_ON);
    chk_bit(tx_ready, 1'b1);
    $display("test reset done");
    // both directions at once in every parity mode
    for (int m = 0; m < 3; m++)
    begin
      parity_en <= modes[m][1];
      parity_odd <= modes[m][0];
      // the host builds its frame at once, so let the new mode settle
      @(posedge ref_clk);
      seed = lfsr(seed);
      a = seed[7:0];
      c = seed[15:8];
      fork
        send_tx(a);
        i_host.send(c);
      join
      tx_chk(a);
      rx_get(c, 3'h0);
    end
    $display("test duplex done");
    // a divider below the limit must clamp to 1 Mbps for the rest
    baud_div <= 16'h0010;
    // clear-to-send held off blocks a start until released
    cts_n <= HS_DEASSERTED;
    repeat (4) @(posedge ref_clk);
    fork
      send_tx(8'h80);
      begin
        repeat (3 * DIV) @(posedge ref_clk);
        chk_bit(tx_ready, 1'b1);
        chk_bit(ser_out, LINE_IDLE);
        cts_n <= HS_ASSERTED;
      end
    join
    tx_chk(8'h80);
    $display("test cts done");
    // wrong parity, then a second character while the first is held
    i_host.bad_par = 1'b1;
    i_host.send(8'hA5);
    i_host.bad_par = 1'b0;
    rx_get(8'hA5, 3'h4);
    clr();
    i_host.ignore_rts = 1'b1;
    i_host.send(8'h3C);
    i_host.send(8'hC3);
    i_host.ignore_rts = 1'b0;
    rx_get(8'h3C, 3'h1);
    clr();
    i_host.bad_stop = 1'b1;
    i_host.send(8'h01);
    i_host.bad_stop = 1'b0;
    rx_get(8'h01, 3'h2);
    // a held-low stop may look like a new start; flush it
    repeat (12 * DIV) @(posedge ref_clk);
    if (rx_valid === 1'b1)
      rx_take <= 1'b1;
    @(posedge ref_clk);
    rx_take <= 1'b0;
    clr();
    $display("test errors done");
    conclude();
  end
endmodule
`default_nettype wire
